//--- door_logic_pkg.sv
// Constants, register map and source numbering of the free logic engine
package door_logic_pkg;

  // Timing
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned TICK_MS = 10;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned DEBOUNCE_MS = 30;
  localparam int unsigned DEBOUNCE_CYCLES = CLK_HZ / 1000 * DEBOUNCE_MS;
  localparam int unsigned FAULT_ACK_S = 5;
  localparam int unsigned FAULT_ACK_TICKS = FAULT_ACK_S * 1000 / TICK_MS;
  localparam int unsigned TIMER_W = 20;
  localparam int unsigned ACK_W = 10;

  // Sizes
  localparam int unsigned NUM_DI = 5;
  localparam int unsigned NUM_SW_BIT = 5;
  localparam int unsigned NUM_REF = 16;
  localparam int unsigned NUM_SLOT = 4;
  localparam int unsigned NUM_Q = 64;

  // Numbered logic outputs
  localparam logic [5:0] Q_LOW = 6'h00;
  localparam logic [5:0] Q_HIGH = 6'h01;
  localparam logic [5:0] Q_DI_LEVEL = 6'h02;
  localparam logic [5:0] Q_DI_INV = 6'h07;
  localparam logic [5:0] Q_DI_EDGE = 6'h0c;
  localparam logic [5:0] Q_CONJ = 6'h11;
  localparam logic [5:0] Q_OR_A = 6'h12;
  localparam logic [5:0] Q_OR_B = 6'h13;
  localparam logic [5:0] Q_XOR = 6'h14;
  localparam logic [5:0] Q_AND2 = 6'h15;
  localparam logic [5:0] Q_INV = 6'h16;
  localparam logic [5:0] Q_DEENERGIZED = 6'h21;
  localparam logic [5:0] Q_STOPPED = 6'h22;
  localparam logic [5:0] Q_OPENED = 6'h23;
  localparam logic [5:0] Q_CLOSED = 6'h24;
  localparam logic [5:0] Q_FAULT = 6'h25;
  localparam logic [5:0] Q_NORMAL = 6'h26;
  localparam logic [5:0] Q_SB_LEVEL = 6'h27;
  localparam logic [5:0] Q_SB_INV = 6'h2c;
  localparam logic [5:0] Q_SB_EDGE = 6'h31;

  // Link-source slots: block inputs, then special blocks
  localparam int unsigned REF_CONJ = 0;
  localparam int unsigned REF_OR_A = 4;
  localparam int unsigned REF_OR_B = 6;
  localparam int unsigned REF_XOR = 8;
  localparam int unsigned REF_AND2 = 10;
  localparam int unsigned REF_INV = 12;
  localparam int unsigned REF_FAULT_ACK = 13;
  localparam int unsigned REF_EMERGENCY = 14;

  // Drive order word
  localparam int unsigned CMD_MSB = 15;
  localparam int unsigned CMD_LSB = 8;
  localparam int unsigned FLAG_MSB = 7;
  localparam logic [7:0] CMD_NONE = 8'h00;
  localparam logic [7:0] CMD_OPEN = 8'h01;
  localparam logic [7:0] CMD_CLOSE = 8'h03;
  localparam logic [7:0] CMD_DEENERGIZE = 8'h04;
  localparam logic [7:0] CMD_STOP = 8'h05;
  localparam logic [7:0] LIGHT_BARRIER_FLAG = 8'h80;
  localparam logic [7:0] DOOR_OPERATION_SELECT_FLAG = 8'h40;
  localparam logic [7:0] FLAG_KEEP_MASK =
    ~(LIGHT_BARRIER_FLAG | DOOR_OPERATION_SELECT_FLAG);

  // Command source setting
  localparam logic [1:0] SRC_BUS = 2'h0;
  localparam logic [1:0] SRC_RELAY = 2'h1;
  localparam logic [1:0] SRC_OFFLINE = 2'h2;
  localparam logic [1:0] SRC_RESET = SRC_BUS;

  // Register map (byte addresses)
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_TECH_TWO = 8'h04;
  localparam logic [7:0] ADDR_REF0 = 8'h08;
  localparam logic [7:0] ADDR_SLOT0 = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h28;
  localparam logic [7:0] ADDR_Q_LO = 8'h2c;
  localparam logic [7:0] ADDR_Q_HI = 8'h30;
  localparam int unsigned SW_BIT_LSB = 10;
  localparam int unsigned SLOT_EN_BIT = 31;
  localparam int unsigned SLOT_SRC_LSB = 16;
  localparam int unsigned REF_FIELD_W = 8;

endpackage

//--- door_free_function_logic.sv
// Free-function logic engine with drive order generation and APB registers
//
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/1ps
module door_free_function_logic #(
  parameter int unsigned TICK_LEN = door_logic_pkg::TICK_CYCLES,
  parameter int unsigned DEBOUNCE_LEN = door_logic_pkg::DEBOUNCE_CYCLES
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Field digital inputs (asynchronous pins)
  input wire logic [door_logic_pkg::NUM_DI-1:0] digital_in,
  // Drive status from the sequencer
  input wire logic motor_deenergized,
  input wire logic motor_stopped,
  input wire logic door_opened,
  input wire logic door_closed,
  input wire logic system_fault,
  input wire logic normal_mode,
  input wire logic operation_state,
  // Drive order and special block outputs
  output logic [15:0] drive_order,
  output logic drive_order_valid,
  output logic bus_command_enable,
  output logic fault_ack,
  output logic emergency_power_request,
  output logic cycle_tick
);
  import door_logic_pkg::*;

  function automatic logic pick(input logic [NUM_Q-1:0] q,
                                input logic [5:0] sel);
    pick = q[sel];
  endfunction

  function automatic logic is_edge_source(input logic [5:0] sel);
    is_edge_source = (sel >= Q_DI_EDGE && sel < Q_DI_EDGE + 6'(NUM_DI)) ||
                     (sel >= Q_SB_EDGE && sel < Q_SB_EDGE + 6'(NUM_SW_BIT));
  endfunction

  // Registers
  logic [1:0] command_source_setting;
  logic [15:0] tech_control_word_two;
  logic [5:0] ref_sel [NUM_REF];
  logic [15:0] slot_order [NUM_SLOT];
  logic [5:0] slot_src [NUM_SLOT];
  logic slot_en [NUM_SLOT];

  // Engine state
  logic [TIMER_W-1:0] tick_cnt;
  logic [NUM_Q-1:0] q_prev;
  logic [NUM_Q-1:0] q_now;
  logic [NUM_DI-1:0] di_meta;
  logic [NUM_DI-1:0] di_sync;
  logic [NUM_DI-1:0] di_level;
  logic [NUM_DI-1:0] di_level_last;
  logic [NUM_SW_BIT-1:0] sw_bit_last;
  logic [NUM_SW_BIT-1:0] software_control_bit;
  logic [15:0] latched_order;
  logic [15:0] next_latched_order;
  logic [15:0] next_drive_order;
  logic next_has_cmd;
  logic [ACK_W-1:0] ack_cnt;
  logic ack_done;

  assign software_control_bit =
    tech_control_word_two[SW_BIT_LSB +: NUM_SW_BIT];

  // Processing cycle tick, free running
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= '0;
      cycle_tick <= 1'b0;
    end else if (tick_cnt == TIMER_W'(TICK_LEN - 1)) begin
      tick_cnt <= '0;
      cycle_tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 1'b1;
      cycle_tick <= 1'b0;
    end
  end

  // Pin synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      di_meta <= '0;
      di_sync <= '0;
    end else begin
      di_meta <= digital_in;
      di_sync <= di_meta;
    end
  end

  // Debounce: a new level is taken only after it has stood the full time
  genvar gi;
  generate
    for (gi = 0; gi < NUM_DI; gi++) begin : g_debounce
      logic [TIMER_W-1:0] stable_cnt;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          stable_cnt <= '0;
          di_level[gi] <= 1'b0;
        end else if (di_sync[gi] == di_level[gi]) begin
          stable_cnt <= '0;
        end else if (stable_cnt == TIMER_W'(DEBOUNCE_LEN - 1)) begin
          stable_cnt <= '0;
          di_level[gi] <= di_sync[gi];
        end else begin
          stable_cnt <= stable_cnt + 1'b1;
        end
      end
    end
  endgenerate

  // Evaluation of one processing cycle; blocks run in ascending order,
  // so any block reading a higher-numbered block's output still sees last cycle's value
  always_comb begin
    q_now = q_prev;
    q_now[Q_LOW] = 1'b0;
    q_now[Q_HIGH] = 1'b1;
    q_now[Q_DI_LEVEL +: NUM_DI] = di_level;
    q_now[Q_DI_INV +: NUM_DI] = ~di_level;
    q_now[Q_DI_EDGE +: NUM_DI] = di_level & ~di_level_last;
    q_now[Q_DEENERGIZED] = motor_deenergized;
    q_now[Q_STOPPED] = motor_stopped;
    q_now[Q_OPENED] = door_opened;
    q_now[Q_CLOSED] = door_closed;
    q_now[Q_FAULT] = system_fault;
    q_now[Q_NORMAL] = normal_mode;
    q_now[Q_SB_LEVEL +: NUM_SW_BIT] = software_control_bit;
    q_now[Q_SB_INV +: NUM_SW_BIT] = ~software_control_bit;
    q_now[Q_SB_EDGE +: NUM_SW_BIT] = software_control_bit & ~sw_bit_last;
    // Conjunction: four inputs, the last two inverted
    q_now[Q_CONJ] = pick(q_now, ref_sel[REF_CONJ]) &&
                    pick(q_now, ref_sel[REF_CONJ + 1]) &&
                    !pick(q_now, ref_sel[REF_CONJ + 2]) &&
                    !pick(q_now, ref_sel[REF_CONJ + 3]);
    q_now[Q_OR_A] = pick(q_now, ref_sel[REF_OR_A]) ||
                    pick(q_now, ref_sel[REF_OR_A + 1]);
    q_now[Q_OR_B] = pick(q_now, ref_sel[REF_OR_B]) ||
                    pick(q_now, ref_sel[REF_OR_B + 1]);
    q_now[Q_XOR] = pick(q_now, ref_sel[REF_XOR]) ^
                   pick(q_now, ref_sel[REF_XOR + 1]);
    q_now[Q_AND2] = pick(q_now, ref_sel[REF_AND2]) &&
                    pick(q_now, ref_sel[REF_AND2 + 1]);
    q_now[Q_INV] = !pick(q_now, ref_sel[REF_INV]);
  end

  // Drive order resolution
  always_comb begin
    logic stop_req;
    logic open_req;
    logic close_req;
    logic [7:0] other_cmd;
    logic [7:0] flags;
    logic [7:0] cmd;
    logic latch_set;
    logic [15:0] latch_val;
    stop_req = 1'b0;
    open_req = 1'b0;
    close_req = 1'b0;
    other_cmd = CMD_NONE;
    flags = 8'h00;
    cmd = CMD_NONE;
    latch_set = 1'b0;
    latch_val = 16'h0000;
    for (int i = 0; i < NUM_SLOT; i++) begin
      if (slot_en[i] && pick(q_now, slot_src[i])) begin
        if (is_edge_source(slot_src[i])) begin
          latch_set = 1'b1;
          latch_val = slot_order[i];
        end else begin
          flags = flags | slot_order[i][FLAG_MSB:0];
          case (slot_order[i][CMD_MSB:CMD_LSB])
            CMD_STOP: stop_req = 1'b1;
            CMD_OPEN: open_req = 1'b1;
            CMD_CLOSE: close_req = 1'b1;
            CMD_NONE: ;
            default: other_cmd = slot_order[i][CMD_MSB:CMD_LSB];
          endcase
        end
      end
    end
    if (stop_req) begin
      cmd = CMD_STOP;
    end else if (open_req) begin
      cmd = CMD_OPEN;
    end else if (close_req) begin
      cmd = CMD_CLOSE;
    end else begin
      cmd = other_cmd;
    end
    // A new edge order wins over a clear in the same cycle
    if (latch_set) begin
      next_latched_order = latch_val;
    end else if (cmd != CMD_NONE && cmd != CMD_DEENERGIZE) begin
      next_latched_order = 16'h0000;
    end else begin
      next_latched_order = latched_order;
    end
    if (cmd == CMD_NONE) begin
      cmd = next_latched_order[CMD_MSB:CMD_LSB];
      flags = flags | next_latched_order[FLAG_MSB:0];
    end
    next_drive_order = {cmd, flags & FLAG_KEEP_MASK};
    // Masked flags alone must not raise an empty order
    next_has_cmd = (cmd != CMD_NONE) || ((flags & FLAG_KEEP_MASK) != 8'h00);
  end

  // Cycle state, taken once per tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_prev <= '0;
      di_level_last <= '0;
      sw_bit_last <= '0;
      latched_order <= 16'h0000;
    end else if (cycle_tick) begin
      q_prev <= q_now;
      di_level_last <= di_level;
      sw_bit_last <= software_control_bit;
      latched_order <= next_latched_order;
    end
  end

  // Drive order output and command source gating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_order <= 16'h0000;
      drive_order_valid <= 1'b0;
      bus_command_enable <= 1'b0;
    end else begin
      bus_command_enable <= (command_source_setting == SRC_BUS);
      if (cycle_tick) begin
        drive_order <= next_drive_order;
        case (command_source_setting)
          SRC_BUS: drive_order_valid <= next_has_cmd && operation_state;
          SRC_RELAY: drive_order_valid <= next_has_cmd;
          SRC_OFFLINE: drive_order_valid <= next_has_cmd;
          default: drive_order_valid <= 1'b0;
        endcase
      end
    end
  end

  // Fault acknowledgement and emergency power blocks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_cnt <= '0;
      ack_done <= 1'b0;
      fault_ack <= 1'b0;
      emergency_power_request <= 1'b0;
    end else begin
      fault_ack <= 1'b0;
      if (cycle_tick) begin
        emergency_power_request <= pick(q_now, ref_sel[REF_EMERGENCY]);
        if (!pick(q_now, ref_sel[REF_FAULT_ACK])) begin
          ack_cnt <= '0;
          ack_done <= 1'b0;
        end else if (ack_cnt != ACK_W'(FAULT_ACK_TICKS - 1)) begin
          ack_cnt <= ack_cnt + 1'b1;
        end else if (!ack_done && system_fault) begin
          ack_done <= 1'b1;
          fault_ack <= 1'b1;
        end
      end
    end
  end

  // APB: zero wait states, read data captured in the setup cycle
  assign pready = 1'b1;

  function automatic logic addr_known(input logic [7:0] a);
    addr_known = (a[1:0] == 2'b00) && (a <= ADDR_Q_HI);
  endfunction

  assign pslverr = psel && penable && !addr_known(paddr);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      command_source_setting <= SRC_RESET;
      tech_control_word_two <= 16'h0000;
      for (int i = 0; i < NUM_REF; i++) begin
        ref_sel[i] <= Q_LOW;
      end
      for (int i = 0; i < NUM_SLOT; i++) begin
        slot_order[i] <= 16'h0000;
        slot_src[i] <= Q_LOW;
        slot_en[i] <= 1'b0;
      end
    end else if (psel && penable && pwrite) begin
      if (paddr == ADDR_CTRL) begin
        command_source_setting <= pwdata[1:0];
      end
      if (paddr == ADDR_TECH_TWO) begin
        tech_control_word_two <= pwdata[15:0];
      end
      for (int r = 0; r < NUM_REF / 4; r++) begin
        if (paddr == ADDR_REF0 + 8'(4 * r)) begin
          for (int k = 0; k < 4; k++) begin
            ref_sel[4 * r + k] <= pwdata[REF_FIELD_W * k +: 6];
          end
        end
      end
      for (int s = 0; s < NUM_SLOT; s++) begin
        if (paddr == ADDR_SLOT0 + 8'(4 * s)) begin
          slot_order[s] <= pwdata[15:0];
          slot_src[s] <= pwdata[SLOT_SRC_LSB +: 6];
          slot_en[s] <= pwdata[SLOT_EN_BIT];
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= 32'h0000_0000;
      if (paddr == ADDR_CTRL) begin
        prdata <= {30'h0000_0000, command_source_setting};
      end
      if (paddr == ADDR_TECH_TWO) begin
        prdata <= {16'h0000, tech_control_word_two};
      end
      for (int r = 0; r < NUM_REF / 4; r++) begin
        if (paddr == ADDR_REF0 + 8'(4 * r)) begin
          prdata <= {2'h0, ref_sel[4 * r + 3], 2'h0, ref_sel[4 * r + 2],
                     2'h0, ref_sel[4 * r + 1], 2'h0, ref_sel[4 * r]};
        end
      end
      for (int s = 0; s < NUM_SLOT; s++) begin
        if (paddr == ADDR_SLOT0 + 8'(4 * s)) begin
          prdata <= {slot_en[s], 9'h000, slot_src[s], slot_order[s]};
        end
      end
      if (paddr == ADDR_STATUS) begin
        prdata <= {1'b0, emergency_power_request, drive_order_valid,
                   di_level, latched_order[CMD_MSB:CMD_LSB], drive_order};
      end
      if (paddr == ADDR_Q_LO) begin
        prdata <= q_prev[31:0];
      end
      if (paddr == ADDR_Q_HI) begin
        prdata <= q_prev[63:32];
      end
    end
  end

endmodule

//--- door_logic_monitor.sv
// Concurrent checks on the free logic engine ports
`timescale 1ns/1ps
module door_logic_monitor #(
  parameter int unsigned TICK_LEN = door_logic_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Drive status
  input wire logic operation_state,
  // Engine outputs
  input wire logic [15:0] drive_order,
  input wire logic drive_order_valid,
  input wire logic bus_command_enable,
  input wire logic fault_ack,
  input wire logic emergency_power_request,
  input wire logic cycle_tick
);
  logic [31:0] gap;
  logic seen;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Only spacing between two ticks is judged; the first one has no mate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap <= '0;
      seen <= 1'b0;
    end else if (cycle_tick) begin
      gap <= '0;
      seen <= 1'b1;
    end else begin
      gap <= gap + 32'h1;
    end
  end

  sequence ack_pulse;
    fault_ack ##1 !fault_ack [*8];
  endsequence

  tick_period_a: assert property (
    cycle_tick && seen |-> gap == TICK_LEN - 1)
    else $error("processing tick spacing wrong");
  tick_pulse_a: assert property (cycle_tick |=> !cycle_tick)
    else $error("processing tick longer than one cycle");
  order_hold_a: assert property (
    !$stable(drive_order) |-> $past(cycle_tick))
    else $error("drive order changed between ticks");
  valid_hold_a: assert property (
    $changed(drive_order_valid) || $changed(emergency_power_request)
    |-> $past(cycle_tick))
    else $error("valid or emergency changed between ticks");
  flags_masked_a: assert property (drive_order[7:6] == 2'b00)
    else $error("masked expansion flags passed through");
  valid_cause_a: assert property (
    drive_order_valid |-> drive_order != 16'h0000)
    else $error("valid drive order is empty");
  bus_gate_a: assert property (
    $past(cycle_tick) && bus_command_enable && !$past(operation_state)
    |-> !drive_order_valid)
    else $error("order executed outside operation state");
  ack_pulse_a: assert property (fault_ack |-> ack_pulse)
    else $error("fault acknowledge not a single pulse");
endmodule

bind door_free_function_logic door_logic_monitor #(.TICK_LEN(TICK_LEN)) mon_u (
  .pclk(pclk), .presetn(presetn), .operation_state(operation_state),
  .drive_order(drive_order), .drive_order_valid(drive_order_valid),
  .bus_command_enable(bus_command_enable), .fault_ack(fault_ack),
  .emergency_power_request(emergency_power_request),
  .cycle_tick(cycle_tick));

//--- field_input_model.sv
// Field side: five digital input pins driven after each rising clock edge
`timescale 1ns/1ps
module field_input_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Requested and driven pin levels
  input wire logic [4:0] want_di,
  output logic [4:0] digital_in
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      digital_in <= 5'h00;
    end else begin
      digital_in <= want_di;
    end
  end
endmodule

//--- tb_top.sv
// Self-checking testbench for the free logic engine
`timescale 1ns/1ps
module tb_top;
  import door_logic_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [4:0] want_di = 5'h00;
  logic [6:0] st = 7'h00;
  logic [31:0] prdata;
  logic pready, pslverr, drive_order_valid, bus_command_enable;
  logic fault_ack, emergency_power_request, cycle_tick;
  logic [15:0] drive_order;
  logic [4:0] digital_in;
  int failures = 0;
  int check_count = 0;
  int acks = 0;

  always #50 pclk = ~pclk;
  always @(posedge pclk) if (fault_ack === 1'b1) acks++;

  field_input_model field_u (.pclk(pclk), .presetn(presetn),
    .want_di(want_di), .digital_in(digital_in));

  // Short tick and debounce keep the run small
  door_free_function_logic #(.TICK_LEN(20), .DEBOUNCE_LEN(5)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .digital_in(digital_in),
    .motor_deenergized(st[0]), .motor_stopped(st[1]), .door_opened(st[2]),
    .door_closed(st[3]), .system_fault(st[4]), .normal_mode(st[5]),
    .operation_state(st[6]), .drive_order(drive_order),
    .drive_order_valid(drive_order_valid),
    .bus_command_enable(bus_command_enable), .fault_ack(fault_ack),
    .emergency_power_request(emergency_power_request),
    .cycle_tick(cycle_tick));

  task automatic finish_test;
    $display("failures=%0d check_count=%0d", failures, check_count);
    if (failures == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      failures++;
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp);
  endtask

  task automatic slot(input int i, input logic [5:0] s, input logic [15:0] o);
    wr(ADDR_SLOT0 + 8'(4 * i), {1'b1, 9'h000, s, o});
  endtask

  // Returns in the cycle after the n-th tick, once outputs have moved
  task automatic ticks(input int n);
    int k;
    k = 0;
    repeat (n) begin
      @(negedge pclk);
      while (cycle_tick !== 1'b1 && k < 20000) begin
        @(negedge pclk);
        k++;
      end
    end
    // A tick that never comes is a mismatch
    if (k >= 20000) begin
      failures++;
    end
    @(negedge pclk);
  endtask

  task automatic ord(input logic v, input logic [15:0] o);
    chk({15'h0, drive_order_valid, drive_order}, {15'h0, v, o});
  endtask

  task automatic s_reset;
    logic [31:0] r;
    logic e;
    rd(ADDR_CTRL, 32'h0);
    rd(ADDR_STATUS, 32'h0);
    chk({31'h0, bus_command_enable}, 32'h1);
    apb(1'b0, 8'h34, 32'h0, r, e);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0);
  endtask

  task automatic s_level;
    wr(ADDR_CTRL, 32'h2);
    slot(0, 6'd2, 16'h01c5);
    @(posedge pclk) want_di <= 5'h01;
    ticks(2);
    ord(1'b1, 16'h0105);
    @(posedge pclk) want_di <= 5'h00;
    ticks(2);
    ord(1'b0, 16'h0000);
    slot(1, 6'd1, 16'h00c0);
    ticks(2);
    ord(1'b0, 16'h0000);
  endtask

  task automatic s_prio;
    slot(0, 6'd1, 16'h0301);
    slot(1, 6'd1, 16'h0102);
    slot(2, 6'd1, 16'h0504);
    ticks(2);
    ord(1'b1, 16'h0507);
    wr(ADDR_SLOT0 + 8'h08, 32'h0);
    ticks(2);
    ord(1'b1, 16'h0103);
    wr(ADDR_SLOT0 + 8'h04, 32'h0);
    ticks(2);
    ord(1'b1, 16'h0301);
  endtask

  task automatic s_gate;
    wr(ADDR_CTRL, 32'h0);
    ticks(2);
    ord(1'b0, 16'h0301);
    @(posedge pclk) st[6] <= 1'b1;
    ticks(2);
    ord(1'b1, 16'h0301);
    wr(ADDR_CTRL, 32'h1);
    @(posedge pclk) st[6] <= 1'b0;
    ticks(2);
    ord(1'b1, 16'h0301);
    chk({31'h0, bus_command_enable}, 32'h0);
    wr(ADDR_CTRL, 32'h3);
    ticks(2);
    ord(1'b0, 16'h0301);
  endtask

  task automatic s_latch;
    wr(ADDR_CTRL, 32'h2);
    slot(0, 6'd49, 16'h0101);
    wr(ADDR_TECH_TWO, 32'h0000_0400);
    ticks(3);
    ord(1'b1, 16'h0101);
    wr(ADDR_TECH_TWO, 32'h0);
    ticks(3);
    ord(1'b1, 16'h0101);
    slot(1, 6'd1, 16'h0400);
    ticks(2);
    ord(1'b1, 16'h0400);
    wr(ADDR_SLOT0 + 8'h04, 32'h0);
    ticks(2);
    ord(1'b1, 16'h0101);
    slot(1, 6'd1, 16'h0300);
    ticks(2);
    wr(ADDR_SLOT0 + 8'h04, 32'h0);
    ticks(2);
    ord(1'b0, 16'h0000);
  endtask

  task automatic s_q;
    wr(ADDR_SLOT0, 32'h0);
    wr(ADDR_REF0, 32'h0000_0116);
    wr(ADDR_REF0 + 8'h0c, 32'h0001_0002);
    @(posedge pclk) st[0] <= 1'b1;
    ticks(2);
    rd(ADDR_Q_LO, 32'h0042_0f82);
    rd(ADDR_Q_HI, 32'h0001_f002);
    chk({31'h0, emergency_power_request}, 32'h1);
    // Inverter drops now; the conjunction reading it lags one tick
    wr(ADDR_REF0 + 8'h0c, 32'h0001_0001);
    ticks(1);
    rd(ADDR_Q_LO, 32'h0002_0f82);
  endtask

  task automatic s_fault;
    int a0;
    @(posedge pclk) st[4] <= 1'b1;
    a0 = acks;
    wr(ADDR_REF0 + 8'h0c, 32'h0001_0102);
    ticks(490);
    chk(32'(acks - a0), 32'h0);
    ticks(15);
    chk(32'(acks - a0), 32'h1);
  endtask

  initial begin
    #5_000_000;
    failures++;
    finish_test;
  end

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    s_reset;
    s_level;
    s_prio;
    s_gate;
    s_latch;
    s_q;
    s_fault;
    finish_test;
  end
endmodule
